// ===== design/gpc_pkg.sv
// Package of constants for the IEEE-488 poll and address controller
package gpc_pkg;
    // Bus command bytes
    localparam logic [7:0] CMD_UNL  = 8'h3f;
    localparam logic [7:0] CMD_UNT  = 8'h5f;
    localparam logic [7:0] CMD_SPE  = 8'h18;
    localparam logic [7:0] CMD_SPD  = 8'h19;
    localparam logic [7:0] CMD_PPC  = 8'h05;
    localparam logic [7:0] CMD_PPU  = 8'h15;
    localparam logic [7:0] LISTEN_BASE = 8'h20;
    localparam logic [7:0] TALK_BASE   = 8'h40;
    // Secondary address window
    localparam logic [7:0] SAD_MIN  = 8'h60;
    localparam logic [7:0] SAD_MAX  = 8'h7e;
    localparam logic [7:0] SAD_OFF  = 8'h7f;
    // Service request bit of a status byte
    localparam int RQS_BIT = 6;
    // Status word bit positions
    localparam int STA_ERR  = 15;
    localparam int STA_TIMEOUT_FLAG = 14;
    localparam int STA_COMPLETE_FLAG = 8;
    // Timing
    localparam int CLK_HZ         = 40_000_000;
    localparam int IFC_MIN_US     = 100;
    localparam int IFC_CYCLES     = (IFC_MIN_US * (CLK_HZ / 1_000_000));
    localparam int PP_SETTLE_NS   = 2000;
    localparam int PP_SETTLE_CYC  = (PP_SETTLE_NS + 24) / 25;
    localparam int TIMEOUT_CYC    = 40_000;
    // Kinds of command sequence
    typedef enum logic [1:0] {
        SEQ_SPOLL = 2'd0,
        SEQ_READ  = 2'd1,
        SEQ_PPCFG = 2'd2,
        SEQ_PPU   = 2'd3
    } gpc_seq_e;
endpackage : gpc_pkg

// ===== design/gpc_poll_ctrl.sv
// Poll, interface clear and addressing controller for an IEEE-488 board
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A parallel poll drives ATN with EOI and latches the eight data lines.
// - A parallel poll while not in charge gives the not-controller error and no bus action.
// - A standby controller first asserts ATN, polls, then stays active.
// - Interface clear and remote enable are only driven while system control is enabled.
// - An external interface clear is obeyed only while not system controller.
// - Serial poll setup sends UNL, talk address, its secondary, own listen, own secondary, SPE.
// - One response byte is read, then UNT, UNL and SPD are sent.
// - Bit 6 of a serial poll response marks a service request; all eight bits, bit 6 included, pass through.
// - With auto polling, a cached positive response is returned without a bus poll.
// - The own status byte answers external polls and bit 6 drives SRQ.
// - Secondary addresses 0x60..0x7E are active; 0x7F or zero disables them.
// - Remote configure sends listen address, PPC, the enable byte, then UNL.
// - The unconfigure command 0x15 can be sent as controller.
// - Status word holds error at bit 15, timeout at 14, completion at 8.
// - A controller read sends UNL, own listen, talk address; after it UNT and UNL.
// - Interface clear holds IFC at least 100 us, then the board is active controller.
module gpc_poll_ctrl
    import gpc_pkg::*;
#(
    parameter int IFC_CYC    = IFC_CYCLES,
    parameter int TMO_CYC    = TIMEOUT_CYC,
    parameter int SETTLE_CYC = PP_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Host requests (one-cycle pulses)
    input  wire logic        parallel_poll_request,
    input  wire logic        serial_poll_request,
    input  wire logic        data_read_request,
    input  wire logic        ppConfigRequest,
    input  wire logic        ppUnconfigRequest,
    input  wire logic        interface_clear_request,
    input  wire logic        remoteEnableSet,
    input  wire logic        remoteEnableValue,
    input  wire logic        own_status_byte_set,
    input  wire logic [7:0]  ownStatusByte,
    input  wire logic        secondary_address_set,
    input  wire logic [7:0]  secondaryAddress,
    // Host configuration levels
    input  wire logic        system_control_request,
    input  wire logic        autoPollEnable,
    input  wire logic [4:0]  ownAddress,
    input  wire logic [4:0]  targetAddress,
    input  wire logic [7:0]  targetSecondary,
    input  wire logic [7:0]  ppEnableByte,
    input  wire logic        controllerInCharge,
    input  wire logic        standbyController,
    input  wire logic        cachedRqs,
    input  wire logic [7:0]  cachedPollByte,
    // Bus pins
    input  wire logic [7:0]  dioIn,
    input  wire logic        davIn,
    input  wire logic        ifcIn,
    input  wire logic        extPollActive,
    output logic      [7:0]  dioOut,
    output logic             dioOe,
    output logic             cmdStrobe,
    input  wire logic        cmdAccepted,
    output logic             atnOut,
    output logic             eoiOut,
    output logic             ifcOut,
    output logic             renOut,
    output logic             srqOut,
    // Results
    output logic      [7:0]  parallel_poll_result,
    output logic      [7:0]  serial_poll_result,
    output logic      [15:0] status_word,
    output logic             not_controller_error,
    output logic             activeController,
    output logic             busy
);
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_PPOLL = 6'b000010,
        ST_CMD   = 6'b000100,
        ST_READ  = 6'b001000,
        ST_POST  = 6'b010000,
        ST_IFC   = 6'b100000
    } gpc_state_e;

    gpc_state_e state_reg;
    logic [7:0]  dioSync1_reg, dioSync_reg;
    logic [2:0]  s1_reg, s_reg;
    logic [31:0] count_reg;
    logic [2:0]  idx_reg;
    gpc_seq_e    seq_reg;
    logic [7:0]  sad_reg;
    logic [7:0]  ownSb_reg;

    // Pin synchronisers: bit0 dav, bit1 ifc, bit2 external poll
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dioSync1_reg <= 8'h00;
            dioSync_reg  <= 8'h00;
            s1_reg       <= 3'h0;
            s_reg        <= 3'h0;
        end else begin
            dioSync1_reg <= dioIn;
            dioSync_reg  <= dioSync1_reg;
            s1_reg       <= {extPollActive, ifcIn, davIn};
            s_reg        <= s1_reg;
        end
    end

    wire sadActive  = (secondaryAddress >= SAD_MIN) && (secondaryAddress <= SAD_MAX);
    wire tgtSadOn   = (targetSecondary >= SAD_MIN) && (targetSecondary <= SAD_MAX);
    wire ownSadOn   = (sad_reg != 8'h00);
    wire [7:0] mla  = LISTEN_BASE | {3'b000, ownAddress};
    wire [7:0] tad  = TALK_BASE | {3'b000, targetAddress};
    wire extIfc     = s_reg[1] && !system_control_request;
    wire cic        = controllerInCharge || standbyController || activeController;

    // Pre-sequence bytes, a zero entry is skipped
    logic [7:0] preByte;
    logic       preLast;
    always_comb begin
        preByte = 8'h00;
        preLast = 1'b0;
        case (seq_reg)
            SEQ_SPOLL: begin
                case (idx_reg)
                    3'd0: preByte = CMD_UNL;
                    3'd1: preByte = tad;
                    3'd2: preByte = tgtSadOn ? targetSecondary : 8'h00;
                    3'd3: preByte = mla;
                    3'd4: preByte = ownSadOn ? sad_reg : 8'h00;
                    default: begin
                        preByte = CMD_SPE;
                        preLast = 1'b1;
                    end
                endcase
            end
            SEQ_READ: begin
                case (idx_reg)
                    3'd0: preByte = CMD_UNL;
                    3'd1: preByte = mla;
                    default: begin
                        preByte = tad;
                        preLast = 1'b1;
                    end
                endcase
            end
            SEQ_PPCFG: begin
                case (idx_reg)
                    3'd0: preByte = LISTEN_BASE | {3'b000, targetAddress};
                    3'd1: preByte = CMD_PPC;
                    3'd2: preByte = ppEnableByte;
                    default: begin
                        preByte = CMD_UNL;
                        preLast = 1'b1;
                    end
                endcase
            end
            default: begin
                preByte = CMD_PPU;
                preLast = 1'b1;
            end
        endcase
    end

    // Post-sequence bytes: after a serial poll UNT, UNL, SPD; after a read UNT, UNL
    wire [7:0] postByte = (idx_reg == 3'd0) ? CMD_UNT :
                          (idx_reg == 3'd1) ? CMD_UNL : CMD_SPD;
    wire postLast = (seq_reg == SEQ_READ) ? (idx_reg == 3'd1) : (idx_reg == 3'd2);
    wire timedOut = (count_reg >= 32'(TMO_CYC));
    wire handOk   = cmdStrobe && cmdAccepted;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 32'h0;
            idx_reg <= 3'h0;
            seq_reg <= SEQ_SPOLL;
            sad_reg <= 8'h00;
            ownSb_reg <= 8'h00;
            dioOut <= 8'h00;
            dioOe <= 1'b0;
            cmdStrobe <= 1'b0;
            atnOut <= 1'b0;
            eoiOut <= 1'b0;
            ifcOut <= 1'b0;
            renOut <= 1'b0;
            srqOut <= 1'b0;
            parallel_poll_result <= 8'h00;
            serial_poll_result <= 8'h00;
            status_word <= 16'h0000;
            not_controller_error <= 1'b0;
            activeController <= 1'b0;
            busy <= 1'b0;
        end else begin
            not_controller_error <= 1'b0;
            srqOut <= ownSb_reg[RQS_BIT];
            if (own_status_byte_set)
                ownSb_reg <= ownStatusByte;
            if (secondary_address_set)
                sad_reg <= sadActive ? secondaryAddress : 8'h00;
            if (remoteEnableSet && system_control_request)
                renOut <= remoteEnableValue;
            else if (!system_control_request)
                renOut <= 1'b0;
            // Answer an external serial poll with the own status byte
            if (s_reg[2] && !activeController) begin
                dioOut <= ownSb_reg;
                dioOe <= 1'b1;
            end else if (state_reg == ST_IDLE) begin
                dioOe <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    count_reg <= 32'h0;
                    idx_reg <= 3'h0;
                    busy <= 1'b0;
                    if (extIfc) begin
                        activeController <= 1'b0;
                        atnOut <= 1'b0;
                    end else if (interface_clear_request) begin
                        if (system_control_request) begin
                            ifcOut <= 1'b1;
                            busy <= 1'b1;
                            status_word <= 16'h0000;
                            state_reg <= ST_IFC;
                        end else begin
                            status_word <= 16'h0000;
                            status_word[STA_ERR] <= 1'b1;
                            status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        end
                    end else if (parallel_poll_request) begin
                        status_word <= 16'h0000;
                        if (!cic) begin
                            not_controller_error <= 1'b1;
                            status_word[STA_ERR] <= 1'b1;
                            status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        end else begin
                            activeController <= 1'b1;
                            atnOut <= 1'b1;
                            eoiOut <= 1'b1;
                            busy <= 1'b1;
                            state_reg <= ST_PPOLL;
                        end
                    end else if (serial_poll_request && autoPollEnable && cachedRqs) begin
                        serial_poll_result <= cachedPollByte;
                        status_word <= 16'h0000;
                        status_word[STA_COMPLETE_FLAG] <= 1'b1;
                    end else if (serial_poll_request || data_read_request
                                 || ppConfigRequest || ppUnconfigRequest) begin
                        status_word <= 16'h0000;
                        if (!cic) begin
                            not_controller_error <= 1'b1;
                            status_word[STA_ERR] <= 1'b1;
                            status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        end else begin
                            seq_reg <= serial_poll_request ? SEQ_SPOLL :
                                       data_read_request ? SEQ_READ :
                                       ppConfigRequest ? SEQ_PPCFG : SEQ_PPU;
                            activeController <= 1'b1;
                            atnOut <= 1'b1;
                            busy <= 1'b1;
                            state_reg <= ST_CMD;
                        end
                    end
                end
                ST_PPOLL: begin
                    count_reg <= count_reg + 32'h1;
                    if (count_reg >= 32'(SETTLE_CYC - 1)) begin
                        parallel_poll_result <= dioSync_reg;
                        eoiOut <= 1'b0;
                        status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CMD, ST_POST: begin
                    count_reg <= count_reg + 32'h1;
                    if (timedOut) begin
                        status_word[STA_TIMEOUT_FLAG] <= 1'b1;
                        status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        cmdStrobe <= 1'b0;
                        dioOe <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (handOk) begin
                        cmdStrobe <= 1'b0;
                        dioOe <= 1'b0;
                        count_reg <= 32'h0;
                        idx_reg <= idx_reg + 3'h1;
                        if (state_reg == ST_CMD && preLast) begin
                            idx_reg <= 3'h0;
                            state_reg <= (seq_reg[1]) ? ST_IDLE : ST_READ;
                            atnOut <= seq_reg[1];
                            if (seq_reg[1])
                                status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        end else if (state_reg == ST_POST && postLast) begin
                            status_word[STA_COMPLETE_FLAG] <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end else if (!cmdStrobe) begin
                        if (state_reg == ST_CMD && preByte == 8'h00) begin
                            idx_reg <= idx_reg + 3'h1;
                        end else begin
                            dioOut <= (state_reg == ST_CMD) ? preByte : postByte;
                            dioOe <= 1'b1;
                            cmdStrobe <= 1'b1;
                        end
                    end
                end
                ST_READ: begin
                    count_reg <= count_reg + 32'h1;
                    if (timedOut) begin
                        status_word[STA_TIMEOUT_FLAG] <= 1'b1;
                        status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (s_reg[0]) begin
                        serial_poll_result <= dioSync_reg;
                        atnOut <= 1'b1;
                        count_reg <= 32'h0;
                        state_reg <= ST_POST;
                    end
                end
                ST_IFC: begin
                    count_reg <= count_reg + 32'h1;
                    if (count_reg >= 32'(IFC_CYC - 1)) begin
                        ifcOut <= 1'b0;
                        activeController <= 1'b1;
                        atnOut <= 1'b1;
                        status_word[STA_COMPLETE_FLAG] <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule : gpc_poll_ctrl

`default_nettype wire

// ===== dv/gpc_poll_ctrl_chk.sv
// Port assertions for the poll and address controller
`timescale 1ns/1ps
`default_nettype none
module gpc_poll_ctrl_chk
    import gpc_pkg::*;
#(
    parameter int IFC_CYC = IFC_CYCLES
) (
    // Clock and reset
    input wire logic        sys_clk, rst,
    // Requests and levels
    input wire logic        parallel_poll_request, own_status_byte_set, system_control_request,
    input wire logic        controllerInCharge, standbyController, cmdAccepted,
    input wire logic [7:0]  ownStatusByte,
    // Outputs watched
    input wire logic [7:0]  dioOut,
    input wire logic        dioOe, cmdStrobe, atnOut, eoiOut, ifcOut, renOut, srqOut,
    input wire logic [15:0] status_word,
    input wire logic        not_controller_error, activeController, busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int  ifcLen;
    wire logic srqBit = ownStatusByte[6];
    // Counts the cycles of one interface clear pulse
    always_ff @(posedge sys_clk) ifcLen <= (rst || !ifcOut) ? 0 : ifcLen + 1;

    a_idy_pair: assert property (eoiOut |-> atnOut)
        else $error("identify without attention");
    a_pp_settle: assert property ($rose(eoiOut) |-> eoiOut [*4])
        else $error("poll sampled before settling");
    a_pp_refused: assert property (parallel_poll_request && !busy && !controllerInCharge
        && !standbyController && !activeController |-> ##[1:3] not_controller_error)
        else $error("missing not-controller error");
    a_refuse_quiet: assert property (not_controller_error |-> !eoiOut && !cmdStrobe)
        else $error("bus action on refused poll");
    a_err_code: assert property (not_controller_error |-> ##[0:2] (status_word[15] && status_word[8]))
        else $error("error status not flagged");
    a_cmd_atn: assert property (cmdStrobe |-> atnOut && dioOe)
        else $error("command byte without attention");
    a_strobe_hold: assert property (cmdStrobe && !cmdAccepted |=> cmdStrobe && $stable(dioOut))
        else $error("command byte changed before acceptance");
    a_ifc_gate: assert property (ifcOut |-> system_control_request)
        else $error("interface clear without system control");
    a_ren_gate: assert property (!system_control_request [*2] |-> !renOut)
        else $error("remote enable without system control");
    a_ifc_width: assert property ($fell(ifcOut) |-> ifcLen >= IFC_CYC)
        else $error("interface clear too short");
    a_srq_follow: assert property (own_status_byte_set |-> ##2 (srqOut == $past(srqBit, 2)))
        else $error("service request line wrong");
endmodule : gpc_poll_ctrl_chk

bind gpc_poll_ctrl gpc_poll_ctrl_chk #(.IFC_CYC(IFC_CYC)) u_gpc_poll_ctrl_chk (
    .sys_clk(sys_clk), .rst(rst), .parallel_poll_request(parallel_poll_request),
    .own_status_byte_set(own_status_byte_set), .system_control_request(system_control_request),
    .controllerInCharge(controllerInCharge), .standbyController(standbyController),
    .cmdAccepted(cmdAccepted), .ownStatusByte(ownStatusByte), .dioOut(dioOut), .dioOe(dioOe),
    .cmdStrobe(cmdStrobe), .atnOut(atnOut), .eoiOut(eoiOut), .ifcOut(ifcOut), .renOut(renOut),
    .srqOut(srqOut), .status_word(status_word), .not_controller_error(not_controller_error),
    .activeController(activeController), .busy(busy));
`default_nettype wire

// ===== dv/gpc_bus_partner.sv
// Behavioural model of the instruments on the bus side
`timescale 1ns/1ps
`default_nettype none
module gpc_bus_partner
    import gpc_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Lines driven by the board
    input  wire logic [7:0] dioOut,
    input  wire logic       cmdStrobe,
    input  wire logic       atnOut,
    input  wire logic       eoiOut,
    // Answers chosen by the bench
    input  wire logic [7:0] respByte,
    input  wire logic [7:0] ppByte,
    input  wire logic [3:0] ackDelay,
    output logic      [7:0] dioIn,
    output logic            davIn,
    output logic            cmdAccepted
);
    logic [7:0] sent[$];
    logic [7:0] idlePat = 8'h5a;
    logic       talker = 1'b0;
    int         waitN = 0;
    initial davIn = 1'b0;
    initial cmdAccepted = 1'b0;
    // Released lines toggle so a stale byte can never pass for an answer
    assign dioIn = (atnOut && eoiOut) ? ppByte : (talker && !atnOut) ? respByte : idlePat;
    always @(posedge sys_clk) begin
        idlePat <= ~idlePat;
        cmdAccepted <= 1'b0;
        davIn <= talker && !atnOut;
        if (cmdStrobe && !cmdAccepted) begin
            if (waitN >= int'(ackDelay)) begin
                cmdAccepted <= 1'b1;
                sent.push_back(dioOut);
                waitN <= 0;
                if (dioOut[7:5] == 3'b010) talker <= (dioOut != CMD_UNT);
            end else begin
                waitN <= waitN + 1;
            end
        end
    end
endmodule : gpc_bus_partner
`default_nettype wire

// ===== dv/test_gpc_poll_ctrl.sv
// Self-checking bench for the poll and address controller
`timescale 1ns/1ps
`default_nettype none
module test_gpc_poll_ctrl;
    import gpc_pkg::*;
    localparam logic [4:0] OWN_ADDR = 5'h01;
    localparam logic [4:0] T_ADDR   = 5'h0c;
    localparam logic [7:0] PPE_BYTE = 8'h6a;
    localparam int         IFC_N    = 10;
    logic        sys_clk = 1'b0, rst = 1'b1, remoteEnableValue = 1'b0, ifcIn = 1'b0;
    logic        system_control_request = 1'b1, autoPollEnable = 1'b0, cachedRqs = 1'b0;
    logic        controllerInCharge = 1'b0, standbyController = 1'b0, errSeen = 1'b0;
    logic [8:0]  reqs = '0;
    logic        extPoll = 1'b0;
    logic [7:0]  ownStatusByte = '0, secondaryAddress = '0, targetSecondary = '0;
    logic [7:0]  cachedPollByte = '0, respByte = '0, ppByte = '0;
    logic [3:0]  ackDelay = '0;
    int          ifcLen = 0, badCount = 0, nChecks = 0;
    logic [7:0]  e[$];
    wire logic [7:0]  dioIn, dioOut, parallel_poll_result, serial_poll_result;
    wire logic [15:0] status_word;
    wire logic   davIn, dioOe, cmdStrobe, cmdAccepted, atnOut, eoiOut, ifcOut, renOut, srqOut;
    wire logic   not_controller_error, activeController, busy;

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (not_controller_error === 1'b1) errSeen <= 1'b1;
        if (ifcOut === 1'b1) ifcLen <= ifcLen + 1;
    end

    gpc_poll_ctrl #(.IFC_CYC(IFC_N), .TMO_CYC(200), .SETTLE_CYC(4)) u_gpc_poll_ctrl (
        .sys_clk(sys_clk), .rst(rst), .parallel_poll_request(reqs[0]),
        .serial_poll_request(reqs[1]), .data_read_request(reqs[2]), .ppConfigRequest(reqs[3]),
        .ppUnconfigRequest(reqs[4]), .interface_clear_request(reqs[5]),
        .remoteEnableSet(reqs[6]), .remoteEnableValue(remoteEnableValue),
        .own_status_byte_set(reqs[7]), .ownStatusByte(ownStatusByte),
        .secondary_address_set(reqs[8]), .secondaryAddress(secondaryAddress),
        .system_control_request(system_control_request), .autoPollEnable(autoPollEnable),
        .ownAddress(OWN_ADDR), .targetAddress(T_ADDR), .targetSecondary(targetSecondary),
        .ppEnableByte(PPE_BYTE), .controllerInCharge(controllerInCharge),
        .standbyController(standbyController), .cachedRqs(cachedRqs),
        .cachedPollByte(cachedPollByte), .dioIn(dioIn), .davIn(davIn), .ifcIn(ifcIn),
        .extPollActive(extPoll), .dioOut(dioOut), .dioOe(dioOe), .cmdStrobe(cmdStrobe),
        .cmdAccepted(cmdAccepted), .atnOut(atnOut), .eoiOut(eoiOut), .ifcOut(ifcOut),
        .renOut(renOut), .srqOut(srqOut), .parallel_poll_result(parallel_poll_result),
        .serial_poll_result(serial_poll_result), .status_word(status_word),
        .not_controller_error(not_controller_error), .activeController(activeController),
        .busy(busy));
    gpc_bus_partner u_gpc_bus_partner (
        .sys_clk(sys_clk), .dioOut(dioOut), .cmdStrobe(cmdStrobe), .atnOut(atnOut),
        .eoiOut(eoiOut), .respByte(respByte), .ppByte(ppByte), .ackDelay(ackDelay),
        .dioIn(dioIn), .davIn(davIn), .cmdAccepted(cmdAccepted));

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            badCount++;
        end
    endtask : chk
    // One request pulse, then a bounded wait until the block is idle again
    task automatic go(input int k);
        int n;
        n = 0;
        u_gpc_bus_partner.sent.delete();
        reqs[k] = 1'b1;
        @(negedge sys_clk);
        reqs = '0;
        repeat (2) @(negedge sys_clk);
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 1000) begin
            chk("busy", 16'h0, {15'h0, busy});
            conclude();
        end
    endtask : go
    task automatic seqChk();
        chk("byte count", 16'(e.size()), 16'(u_gpc_bus_partner.sent.size()));
        foreach (e[i]) if (i < u_gpc_bus_partner.sent.size())
            chk("command byte", {8'h0, e[i]}, {8'h0, u_gpc_bus_partner.sent[i]});
    endtask : seqChk
    task automatic tRefused();
        go(0);
        chk("error pulse", 16'h1, {15'h0, errSeen});
        chk("status", 16'h8100, status_word);
    endtask : tRefused
    task automatic tNoSc();
        system_control_request = 1'b0;
        remoteEnableValue = 1'b1;
        go(6);
        chk("ren", 16'h0, {15'h0, renOut});
        go(5);
        chk("status", 16'h8100, status_word);
        chk("ifc cycles", 16'h0, 16'(ifcLen));
        system_control_request = 1'b1;
        go(6);
        chk("ren", 16'h1, {15'h0, renOut});
    endtask : tNoSc
    task automatic tPp();
        standbyController = 1'b1;
        ppByte = 8'h96;
        go(0);
        chk("pp result", 16'h0096, {8'h0, parallel_poll_result});
        chk("status", 16'h0100, status_word);
        standbyController = 1'b0;
        chk("active", 16'h1, {15'h0, activeController});
    endtask : tPp
    task automatic spoll(input logic [7:0] own, tsec, resp, input logic [3:0] dly);
        secondaryAddress = own;
        targetSecondary = tsec;
        respByte = resp;
        ackDelay = dly;
        go(8);
        e = {CMD_UNL, TALK_BASE | 8'(T_ADDR)};
        if (tsec inside {[SAD_MIN:SAD_MAX]}) e.push_back(tsec);
        e.push_back(LISTEN_BASE | 8'(OWN_ADDR));
        if (own inside {[SAD_MIN:SAD_MAX]}) e.push_back(own);
        e = {e, CMD_SPE, CMD_UNT, CMD_UNL, CMD_SPD};
        go(1);
        seqChk();
        chk("spoll result", {8'h0, resp}, {8'h0, serial_poll_result});
    endtask : spoll
    task automatic tCache();
        autoPollEnable = 1'b1;
        cachedRqs = 1'b1;
        cachedPollByte = 8'h47;
        go(1);
        chk("bytes sent", 16'h0, 16'(u_gpc_bus_partner.sent.size()));
        chk("cached", 16'h0047, {8'h0, serial_poll_result});
        cachedRqs = 1'b0;
        spoll(8'h00, 8'h00, 8'h55, 4'd1);
        autoPollEnable = 1'b0;
    endtask : tCache
    task automatic tAddr();
        respByte = 8'h33;
        e = {CMD_UNL, LISTEN_BASE | 8'(OWN_ADDR), TALK_BASE | 8'(T_ADDR), CMD_UNT, CMD_UNL};
        go(2);
        seqChk();
        chk("read", 16'h0033, {8'h0, serial_poll_result});
        e = {LISTEN_BASE | 8'(T_ADDR), CMD_PPC, PPE_BYTE, CMD_UNL};
        go(3);
        seqChk();
        e = {CMD_PPU};
        go(4);
        seqChk();
    endtask : tAddr
    task automatic tSrq();
        ownStatusByte = 8'h41;
        go(7);
        chk("srq", 16'h1, {15'h0, srqOut});
        ownStatusByte = 8'h01;
        go(7);
        chk("srq", 16'h0, {15'h0, srqOut});
    endtask : tSrq
    task automatic tIfc();
        ifcLen = 0;
        go(5);
        chk("ifc long", 16'h1, {15'h0, ifcLen >= IFC_N});
        chk("active atn", 16'h3, {14'h0, activeController, atnOut});
        for (int sc = 1; sc >= 0; sc--) begin
            system_control_request = sc[0];
            ifcIn = 1'b1;
            repeat (6) @(negedge sys_clk);
            ifcIn = 1'b0;
            repeat (4) @(negedge sys_clk);
            chk("active", {15'h0, sc[0]}, {15'h0, activeController});
        end
        extPoll = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("poll answer", 16'h0101, {7'h0, dioOe, dioOut});
    endtask : tIfc

    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        tRefused();
        tNoSc();
        tPp();
        spoll(8'h6a, 8'h6b, 8'h41, 4'd3);
        spoll(8'h7e, 8'h60, 8'hbf, 4'd0);
        spoll(8'h7f, 8'h7f, 8'hc0, 4'd2);
        spoll(8'h00, 8'h00, 8'h02, 4'd0);
        tCache();
        tAddr();
        tSrq();
        tIfc();
        conclude();
    end
endmodule : test_gpc_poll_ctrl
`default_nettype wire
